//--- hw/drain_fault_pkg.sv
// Package: constants and carrier types for the drain-source fault monitor
package drain_fault_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int BLANK_STEP_NS = 250;
  localparam int FILTER_STEP_NS = 125;
  // Least times, so round up to whole cycles
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int FILTER_STEP_CYC = (FILTER_STEP_NS * CLK_MHZ + 999) / 1000;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int SENSORS = 6;
  localparam int HALF = 3;
  localparam int TH_W = 4;
  localparam int CODE_W = 4;
  localparam int CNT_W = 10;
  localparam int SYNC_W = 2 * HALF + SENSORS + 1;

  typedef logic [CNT_W-1:0] count_t;
  typedef logic [SENSORS-1:0] sensor_vec_t;

  // Fault report selection
  localparam logic REPORT_PIN = 1'b0;
  localparam logic REPORT_STATUS_ONLY = 1'b1;

  // Reset values
  localparam sensor_vec_t STATUS_RST = 6'h00;
  localparam sensor_vec_t OE_N_RST = 6'h3f;

  // Configuration written by the serial interface
  typedef struct packed {
    logic [TH_W-1:0] highSideThreshold;
    logic [TH_W-1:0] lowSideThreshold;
    logic [CODE_W-1:0] sensorDeglitchTime;
    logic [CODE_W-1:0] sensorBlankTime;
    logic sensorFaultReportCfg;
    logic offStateDiagEnable;
    logic drainSensorEnable;
  } sensor_cfg_t;

  // Setting code to cycle count: (code + 1) steps
  function automatic count_t code_cycles(input logic [CODE_W-1:0] code, input int step);
    code_cycles = count_t'((int'(code) + 1) * step);
  endfunction

endpackage

//--- hw/sensor_channel.sv
// One drain-source sensor channel: blanking then deglitch filter
`timescale 1ns/1ps
`default_nettype none
module sensor_channel (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic armed,
  input wire logic compIn,
  input wire drain_fault_pkg::count_t blankCycles,
  input wire drain_fault_pkg::count_t filterCycles,
  output logic faultHit
);

  typedef enum logic [1:0] {IDLE, BLANK, WATCH} chan_state_t;

  chan_state_t state_ff, nxt_state;
  drain_fault_pkg::count_t cnt_ff, nxt_cnt;
  logic hit_ff, nxt_hit;

  // ************************************************************
  // Blank and filter sequencing
  // ************************************************************
  // One counter serves both phases, they never overlap
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_hit = 1'b0;
    case (state_ff)
      IDLE: begin
        nxt_cnt = '0;
        if (armed) begin
          nxt_state = BLANK;
        end
      end
      BLANK: begin
        nxt_cnt = cnt_ff + 1'b1; // R4
        if (cnt_ff + 1'b1 >= blankCycles) begin
          nxt_state = WATCH;
          nxt_cnt = '0;
        end
      end
      WATCH: begin
        if (!compIn) begin
          nxt_cnt = '0; // R16
        end else if (cnt_ff >= filterCycles) begin
          nxt_hit = 1'b1; // R5
          nxt_cnt = '0;
        end else begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      default: begin
        nxt_state = IDLE;
        nxt_cnt = '0;
      end
    endcase
    // Disarming drops everything at once, whatever the phase
    if (!armed) begin
      nxt_state = IDLE; // R3
      nxt_cnt = '0; // R16
      nxt_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= IDLE;
      cnt_ff <= '0;
      hit_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      hit_ff <= nxt_hit;
    end
  end

  assign faultHit = hit_ff;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_armStart;
    $rose(armed);
  endsequence

  sequence s_quietBlank;
    !faultHit [*8];
  endsequence

  a_blank_quiet: assert property (@(posedge clk_sys) disable iff (reset) // R4
    s_armStart |-> s_quietBlank) else $error("Hit during blanking");

  a_filter_length: assert property (@(posedge clk_sys) disable iff (reset) // R5
    faultHit |-> $past(compIn) && ($past(cnt_ff) == $past(filterCycles)) && $past(state_ff) == WATCH)
    else $error("Hit without full filter time");

  a_timer_clear: assert property (@(posedge clk_sys) disable iff (reset) // R16
    (!armed || (state_ff == WATCH && !compIn)) |=> cnt_ff == '0) else $error("Filter timer not cleared");

  a_disarm_quiet: assert property (@(posedge clk_sys) disable iff (reset) // R3
    !armed |=> !faultHit) else $error("Hit from disarmed sensor");

endmodule
`default_nettype wire

//--- hw/drain_source_fault_monitor.sv
// Top: six drain-source sensors, fault latching, diagnostics and gate control
// Overview of operation
// R1: One sensor for each of six MOSFETs
// R2: Separate thresholds for high and low side
// R3: Sensor armed only while its MOSFET on
// R4: Ignore result during blanking after gate turn-on
// R5: Fault only if comparator outlasts filter time
// R6: Normal fault stops inverter, drives fault pin
// R7: Report setting picks status only or pin
// R8: Status bit per sensor, readable by controller
// R9: Faults latched until controller clears or power
// R10: Diagnostics arms sensors from PWM, gates undriven
// R11: Diagnostic faults set status only, never pin
// R12: Controller uses diagnostics only in six-input mode
// R13: Controller sets bits with enable low first
// R14: Diagnostics: sensors on, amplifiers off, gates open
// R15: Normal: amplifiers on, gates follow PWM inputs
// R16: Filter timer restarts on drop, cleared when idle
// R17: Blank and filter counted in clock cycles
`timescale 1ns/1ps
`default_nettype none
module drain_source_fault_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic driverEnablePin,
  input wire logic [drain_fault_pkg::HALF-1:0] highSidePwmIn,
  input wire logic [drain_fault_pkg::HALF-1:0] lowSidePwmIn,
  input wire logic [drain_fault_pkg::SENSORS-1:0] sensorCompRaw,
  input wire drain_fault_pkg::sensor_cfg_t sensorCfg,
  input wire logic faultClear,
  output logic [drain_fault_pkg::HALF-1:0] gateHigh,
  output logic [drain_fault_pkg::HALF-1:0] gateLow,
  output logic [drain_fault_pkg::SENSORS-1:0] gateDriveOe_n,
  output logic [drain_fault_pkg::SENSORS-1:0] sensorArm,
  output logic [drain_fault_pkg::TH_W-1:0] highSideThreshold,
  output logic [drain_fault_pkg::TH_W-1:0] lowSideThreshold,
  output logic currentAmplifiersEnable,
  output logic chargePumpEnable,
  output logic [drain_fault_pkg::SENSORS-1:0] sensorStatus,
  output logic inverterStopped,
  output logic fault_out_n
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Enable, PWM and comparator levels all come from outside the clock
  logic [drain_fault_pkg::SYNC_W-1:0] syncA_ff, syncB_ff;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= {sensorCompRaw, lowSidePwmIn, highSidePwmIn, driverEnablePin};
      syncB_ff <= syncA_ff;
    end
  end

  logic enSync;
  drain_fault_pkg::sensor_vec_t cmdOn, compSync;
  assign enSync = syncB_ff[0];
  // Bits 0..2 high side A..C, bits 3..5 low side A..C
  assign cmdOn = syncB_ff[2*drain_fault_pkg::HALF:1];
  assign compSync = syncB_ff[drain_fault_pkg::SYNC_W-1:2*drain_fault_pkg::HALF+1];

  // ************************************************************
  // Mode decode
  // ************************************************************
  logic inverterStop_ff, nxt_inverterStop;
  logic normalMode, diagMode, driving;
  assign normalMode = enSync && !sensorCfg.offStateDiagEnable; // R15
  assign diagMode = enSync && sensorCfg.offStateDiagEnable; // R14
  assign driving = normalMode && !inverterStop_ff;

  // ************************************************************
  // Sensor channels
  // ************************************************************
  drain_fault_pkg::count_t blankCycles, filterCycles;
  drain_fault_pkg::sensor_vec_t hit;
  assign blankCycles = drain_fault_pkg::code_cycles(sensorCfg.sensorBlankTime,
                                                   drain_fault_pkg::BLANK_STEP_CYC); // R17
  assign filterCycles = drain_fault_pkg::code_cycles(sensorCfg.sensorDeglitchTime,
                                                    drain_fault_pkg::FILTER_STEP_CYC); // R17

  logic [drain_fault_pkg::SENSORS-1:0] sensorArm_ff, nxt_sensorArm;

  // One independent channel per external MOSFET
  for (genvar i = 0; i < drain_fault_pkg::SENSORS; i++) begin : g_chan
    sensor_channel u_chan ( // R1
      .clk_sys(clk_sys),
      .reset(reset),
      .armed(sensorArm_ff[i]),
      .compIn(compSync[i]),
      .blankCycles(blankCycles),
      .filterCycles(filterCycles),
      .faultHit(hit[i])
    );
  end

  // ************************************************************
  // Gate, sensor and supply control
  // ************************************************************
  logic [drain_fault_pkg::HALF-1:0] gateHigh_ff, gateLow_ff, nxt_gateHigh, nxt_gateLow;
  drain_fault_pkg::sensor_vec_t gateDriveOe_n_ff, nxt_gateDriveOe_n;
  logic [drain_fault_pkg::TH_W-1:0] hsTh_ff, lsTh_ff;
  logic amp_ff, nxt_amp, cp_ff, nxt_cp;

  // Arm and gate flops switch in the same cycle so blanking starts at gate activation
  always_comb begin
    nxt_sensorArm = '0;
    nxt_gateHigh = '0;
    nxt_gateLow = '0;
    nxt_gateDriveOe_n = drain_fault_pkg::OE_N_RST;
    if (sensorCfg.drainSensorEnable && (driving || diagMode)) begin
      nxt_sensorArm = cmdOn; // R3 R10
    end
    if (driving) begin
      nxt_gateHigh = cmdOn[drain_fault_pkg::HALF-1:0]; // R15
      nxt_gateLow = cmdOn[drain_fault_pkg::SENSORS-1:drain_fault_pkg::HALF];
      nxt_gateDriveOe_n = '0;
    end
    // Diagnostics and stop leave the gates released
    nxt_amp = normalMode; // R14 R15
    nxt_cp = enSync; // R14
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sensorArm_ff <= '0;
      gateHigh_ff <= '0;
      gateLow_ff <= '0;
      gateDriveOe_n_ff <= drain_fault_pkg::OE_N_RST;
      hsTh_ff <= '0;
      lsTh_ff <= '0;
      amp_ff <= 1'b0;
      cp_ff <= 1'b0;
    end else begin
      sensorArm_ff <= nxt_sensorArm;
      gateHigh_ff <= nxt_gateHigh;
      gateLow_ff <= nxt_gateLow;
      gateDriveOe_n_ff <= nxt_gateDriveOe_n;
      hsTh_ff <= sensorCfg.highSideThreshold; // R2
      lsTh_ff <= sensorCfg.lowSideThreshold; // R2
      amp_ff <= nxt_amp;
      cp_ff <= nxt_cp;
    end
  end

  // ************************************************************
  // Fault latching and reporting
  // ************************************************************
  drain_fault_pkg::sensor_vec_t status_ff, nxt_status;
  logic pinLatch_ff, nxt_pinLatch;
  logic faultOut_n_ff, nxt_faultOut_n;
  logic normalHit;

  // A hit seen while armed in normal mode stops the bridge; diagnostic hits do not
  assign normalHit = (|hit) && normalMode;

  // Set wins over clear so a fault in the clearing cycle survives
  always_comb begin
    nxt_status = status_ff;
    nxt_inverterStop = inverterStop_ff;
    nxt_pinLatch = pinLatch_ff;
    if (faultClear) begin
      nxt_status = '0; // R9
      nxt_inverterStop = 1'b0;
      nxt_pinLatch = 1'b0;
    end
    nxt_status = nxt_status | hit; // R8 R11
    if (normalHit) begin
      nxt_inverterStop = 1'b1; // R6
      if (sensorCfg.sensorFaultReportCfg == drain_fault_pkg::REPORT_PIN) begin
        nxt_pinLatch = 1'b1; // R7
      end
    end
    // Active-low copy kept in its own flop so the pin has no gate after it
    nxt_faultOut_n = !nxt_pinLatch; // R6
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_ff <= drain_fault_pkg::STATUS_RST;
      inverterStop_ff <= 1'b0;
      pinLatch_ff <= 1'b0;
      faultOut_n_ff <= 1'b1;
    end else begin
      status_ff <= nxt_status;
      inverterStop_ff <= nxt_inverterStop;
      pinLatch_ff <= nxt_pinLatch;
      faultOut_n_ff <= nxt_faultOut_n;
    end
  end

  assign gateHigh = gateHigh_ff;
  assign gateLow = gateLow_ff;
  assign gateDriveOe_n = gateDriveOe_n_ff;
  assign sensorArm = sensorArm_ff;
  assign highSideThreshold = hsTh_ff;
  assign lowSideThreshold = lsTh_ff;
  assign currentAmplifiersEnable = amp_ff;
  assign chargePumpEnable = cp_ff;
  assign sensorStatus = status_ff;
  assign inverterStopped = inverterStop_ff;
  assign fault_out_n = faultOut_n_ff; // Straight from a flop, glitch free

  // ************************************************************
  // Checks
  // ************************************************************
  a_pin_source: assert property (@(posedge clk_sys) disable iff (reset) // R11
    $rose(pinLatch_ff) |-> $past(normalMode) && $past(|hit)
      && $past(sensorCfg.sensorFaultReportCfg) == drain_fault_pkg::REPORT_PIN)
    else $error("Fault pin set without normal-mode pin report");

  a_status_only: assert property (@(posedge clk_sys) disable iff (reset) // R7
    ((|hit) && sensorCfg.sensorFaultReportCfg == drain_fault_pkg::REPORT_STATUS_ONLY && !pinLatch_ff)
      |=> !pinLatch_ff) else $error("Status-only fault reached pin");

  a_fault_latch: assert property (@(posedge clk_sys) disable iff (reset) // R9
    (inverterStop_ff && !faultClear) |=> inverterStop_ff && (status_ff != '0))
    else $error("Fault dropped without clear");

  a_status_set: assert property (@(posedge clk_sys) disable iff (reset) // R8
    (|hit) |=> (status_ff & $past(hit)) == $past(hit)) else $error("Status bit not set");

  a_stop_gates: assert property (@(posedge clk_sys) disable iff (reset) // R6
    normalHit |=> ##1 (gateDriveOe_n == drain_fault_pkg::OE_N_RST) && gateHigh == '0 && gateLow == '0)
    else $error("Gates still driven after fault");

  a_diag_undriven: assert property (@(posedge clk_sys) disable iff (reset) // R10
    diagMode |=> (gateDriveOe_n == drain_fault_pkg::OE_N_RST) && !currentAmplifiersEnable && chargePumpEnable)
    else $error("Diagnostics drove gates or amplifiers");

  a_enable_low: assert property (@(posedge clk_sys) disable iff (reset) // R14
    !enSync |=> sensorArm == '0 && !currentAmplifiersEnable && !chargePumpEnable)
    else $error("Outputs active with enable low");

  a_normal_follow: assert property (@(posedge clk_sys) disable iff (reset) // R15
    driving |=> gateHigh == $past(cmdOn[drain_fault_pkg::HALF-1:0]) && currentAmplifiersEnable
      && gateDriveOe_n == '0) else $error("Gates not following PWM");

endmodule
`default_nettype wire

//--- sim/bridge_sense_model.sv
// Behavioural model of the six comparators that watch the external MOSFETs
`timescale 1ns/1ps
`default_nettype none
module bridge_sense_model (
  input wire logic clk_sys,
  input wire logic [5:0] overload,
  output logic [5:0] sensorCompRaw
);
  // ************************************************************
  // Comparator response
  // ************************************************************
  // Output follows the overload level even when the sensor is not armed,
  // so the monitor itself must gate it; a kinder model would hide that
  always_ff @(posedge clk_sys) begin
    sensorCompRaw <= overload;
  end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Self-checking testbench for the drain-source fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ************************************************************
  // Signals
  // ************************************************************
  typedef struct packed {
    logic diag; logic en; logic sense; logic [2:0] hs; logic [2:0] ls; logic [3:0] thHi; logic [3:0] thLo;
    logic [2:0] gh; logic [2:0] gl; logic [5:0] oeN; logic [5:0] arm; logic amp; logic cp;
  } row_t;
  row_t rows [5];
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic driverEnablePin = 1'b0;
  logic [2:0] highSidePwmIn = 3'h0;
  logic [2:0] lowSidePwmIn = 3'h0;
  logic [5:0] overload = 6'h00;
  logic faultClear = 1'b0;
  drain_fault_pkg::sensor_cfg_t sensorCfg = '0;
  logic [5:0] sensorCompRaw, gateDriveOe_n, sensorArm, sensorStatus;
  logic [2:0] gateHigh, gateLow;
  logic [3:0] highSideThreshold, lowSideThreshold;
  logic currentAmplifiersEnable, chargePumpEnable, inverterStopped, fault_out_n;
  int badCount = 0;
  int testsRun = 0;
  // Ticks to the hit flop with both codes at 1: two sync stages, arm flop,
  // idle to blank, the blank itself, then F+1 filter samples
  localparam int HIT_TICKS = 5 + 2 * drain_fault_pkg::BLANK_STEP_CYC + 2 * drain_fault_pkg::FILTER_STEP_CYC;

  always #4 clk_sys = ~clk_sys;

  drain_source_fault_monitor u_drain_source_fault_monitor (.clk_sys(clk_sys), .reset(reset),
    .driverEnablePin(driverEnablePin), .highSidePwmIn(highSidePwmIn), .lowSidePwmIn(lowSidePwmIn),
    .sensorCompRaw(sensorCompRaw), .sensorCfg(sensorCfg), .faultClear(faultClear), .gateHigh(gateHigh),
    .gateLow(gateLow), .gateDriveOe_n(gateDriveOe_n), .sensorArm(sensorArm),
    .highSideThreshold(highSideThreshold), .lowSideThreshold(lowSideThreshold),
    .currentAmplifiersEnable(currentAmplifiersEnable), .chargePumpEnable(chargePumpEnable),
    .sensorStatus(sensorStatus), .inverterStopped(inverterStopped), .fault_out_n(fault_out_n));

  bridge_sense_model u_bridge_sense_model (.clk_sys(clk_sys), .overload(overload), .sensorCompRaw(sensorCompRaw));

  // ************************************************************
  // Tasks
  // ************************************************************
  // Inputs always move 1 ns after the edge, clear of the sampling instant
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task finish_test();
    if (badCount == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task cmp_vec(input logic [5:0] got, input logic [5:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("unexpected %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp, input string what);
    cmp_vec({5'h00, got}, {5'h00, exp}, what);
  endtask

  // Configuration is written with the enable pin low, then the pin is driven to en
  task set_mode(input logic diag, input logic en, input logic sense, input logic rep);
    driverEnablePin = 1'b0;
    tick(4);
    sensorCfg.offStateDiagEnable = diag;
    sensorCfg.drainSensorEnable = sense;
    sensorCfg.sensorFaultReportCfg = rep;
    tick(1);
    driverEnablePin = en;
    tick(8);
  endtask

  task wait_status(input int idx);
    int k;
    k = 0;
    while (sensorStatus[idx] !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    if (k == 300) begin
      badCount++;
      $display("unexpected %0t: no fault on sensor %0d", $time, idx);
      finish_test();
    end
  endtask

  // Blanked overload, split glitch, real fault, latch, clear and resume on one sensor
  task fault_case(input int idx, input logic diag, input logic rep, input logic expPin, input logic expStop);
    logic [5:0] mask;
    mask = 6'h01 << idx;
    overload = 6'h00;
    {lowSidePwmIn, highSidePwmIn} = 6'h00;
    set_mode(diag, 1'b1, 1'b1, rep);
    {lowSidePwmIn, highSidePwmIn} = mask;
    overload = mask;
    tick(24);
    overload = 6'h00;
    tick(30);
    cmp_vec(sensorStatus, 6'h00, "overload while blanked");
    overload = mask;
    tick(10);
    overload = 6'h00;
    tick(2);
    overload = mask;
    tick(10);
    overload = 6'h00;
    tick(8);
    cmp_vec(sensorStatus, 6'h00, "split glitch");
    overload = mask;
    wait_status(idx);
    cmp_vec(sensorStatus, mask, "status bit");
    cmp_bit(fault_out_n, expPin, "fault pin");
    cmp_bit(inverterStopped, expStop, "stop latch");
    tick(2);
    cmp_vec({gateLow, gateHigh}, 6'h00, "gates after fault");
    cmp_vec(sensorArm, expStop ? 6'h00 : mask, "arm after fault");
    overload = 6'h00;
    tick(20);
    cmp_vec(sensorStatus, mask, "status held");
    cmp_bit(fault_out_n, expPin, "pin held");
    faultClear = 1'b1;
    tick(1);
    faultClear = 1'b0;
    tick(1);
    cmp_vec(sensorStatus, 6'h00, "status cleared");
    cmp_bit(fault_out_n, 1'b1, "pin released");
    cmp_bit(inverterStopped, 1'b0, "stop released");
    tick(4);
    cmp_vec({gateLow, gateHigh}, diag ? 6'h00 : mask, "gates resume");
    cmp_vec(sensorArm, mask, "arm resumes");
    {lowSidePwmIn, highSidePwmIn} = 6'h00;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    rows[0] = '{1'b0, 1'b0, 1'b1, 3'h7, 3'h0, 4'h3, 4'hc, 3'h0, 3'h0, 6'h3f, 6'h00, 1'b0, 1'b0};
    rows[1] = '{1'b0, 1'b1, 1'b1, 3'h5, 3'h2, 4'ha, 4'h5, 3'h5, 3'h2, 6'h00, 6'h15, 1'b1, 1'b1};
    rows[2] = '{1'b0, 1'b1, 1'b0, 3'h2, 3'h5, 4'h1, 4'he, 3'h2, 3'h5, 6'h00, 6'h00, 1'b1, 1'b1};
    rows[3] = '{1'b1, 1'b1, 1'b1, 3'h3, 3'h4, 4'h6, 4'h9, 3'h0, 3'h0, 6'h3f, 6'h23, 1'b0, 1'b1};
    rows[4] = '{1'b1, 1'b0, 1'b1, 3'h7, 3'h7, 4'hf, 4'h0, 3'h0, 3'h0, 6'h3f, 6'h00, 1'b0, 1'b0};
    tick(20);
    reset = 1'b0;
    tick(1);
    cmp_vec({gateLow, gateHigh}, 6'h00, "gates at reset");
    cmp_vec(gateDriveOe_n, 6'h3f, "oe at reset");
    cmp_vec(sensorArm, 6'h00, "arm at reset");
    cmp_vec(sensorStatus, 6'h00, "status at reset");
    cmp_bit(fault_out_n, 1'b1, "pin at reset");
    cmp_bit(inverterStopped, 1'b0, "stop at reset");
    // Mode table: enable pin, diagnostics, sensor enable against the outputs
    foreach (rows[i]) begin
      highSidePwmIn = rows[i].hs;
      lowSidePwmIn = rows[i].ls;
      sensorCfg.highSideThreshold = rows[i].thHi;
      sensorCfg.lowSideThreshold = rows[i].thLo;
      set_mode(rows[i].diag, rows[i].en, rows[i].sense, 1'b0);
      cmp_vec({gateLow, gateHigh}, {rows[i].gl, rows[i].gh}, "gate commands");
      cmp_vec(gateDriveOe_n, rows[i].oeN, "gate enables");
      cmp_vec(sensorArm, rows[i].arm, "sensor arms");
      cmp_bit(currentAmplifiersEnable, rows[i].amp, "amplifiers");
      cmp_bit(chargePumpEnable, rows[i].cp, "charge pump");
      cmp_vec({2'h0, highSideThreshold}, {2'h0, rows[i].thHi}, "high threshold");
      cmp_vec({2'h0, lowSideThreshold}, {2'h0, rows[i].thLo}, "low threshold");
    end
    // Overload on every sensor while none is commanded on
    highSidePwmIn = 3'h0;
    lowSidePwmIn = 3'h0;
    set_mode(1'b0, 1'b1, 1'b1, 1'b0);
    overload = 6'h3f;
    tick(100);
    overload = 6'h00;
    cmp_vec(sensorStatus, 6'h00, "disarmed overload");
    cmp_bit(fault_out_n, 1'b1, "disarmed pin");
    fault_case(0, 1'b0, 1'b0, 1'b0, 1'b1);
    fault_case(4, 1'b0, 1'b1, 1'b1, 1'b1);
    fault_case(3, 1'b1, 1'b0, 1'b1, 1'b0);
    fault_case(2, 1'b0, 1'b0, 1'b0, 1'b1);
    // Longer codes, exact hit cycle, and a clear in the hit cycle itself
    sensorCfg.sensorBlankTime = 4'h1;
    sensorCfg.sensorDeglitchTime = 4'h1;
    set_mode(1'b0, 1'b1, 1'b1, 1'b0);
    highSidePwmIn = 3'h1;
    overload = 6'h01;
    tick(HIT_TICKS);
    cmp_vec(sensorStatus, 6'h00, "no early hit");
    // Set must win, so the bit survives this clear
    faultClear = 1'b1;
    tick(1);
    faultClear = 1'b0;
    cmp_vec(sensorStatus, 6'h01, "set wins over clear");
    cmp_bit(fault_out_n, 1'b0, "pin on timed hit");
    cmp_bit(inverterStopped, 1'b1, "stop on timed hit");
    // Reset in mid-run drops every latch
    overload = 6'h00;
    highSidePwmIn = 3'h0;
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    tick(1);
    cmp_vec(sensorStatus, 6'h00, "status after reset");
    cmp_bit(fault_out_n, 1'b1, "pin after reset");
    cmp_bit(inverterStopped, 1'b0, "stop after reset");
    cmp_vec(gateDriveOe_n, 6'h3f, "oe after reset");
    finish_test();
  end
endmodule
`default_nettype wire
